// *** pin_select_pkg.sv ***
// Purpose: Constants for the shared-pin function selector.
// Assumes: One system clock, synchronous active-low reset.
// Notes: Register offsets are word indices on the plain register port.
//
// Summary of operation
// - Port data read gives pin level when direction is 0, else output latch.
// - A peripheral output drives its pin regardless of the direction bit.
// - Port-0 pin 6 is analog channel 1 on input, channel 001, group 0.
// - Port-0 pin 7 is analog channel 0 on input, channel 000, group 0.
// - Port-1 pin 0 is analog channel 8 on input, channel 100, group 1.
// - Port-1 pin 1 is analog channel 9 on input, channel 101, group 1.
// - Port-1 pin 2 is analog channel 10 on input, channel 110, group 1.
// - Port-1 pin 3 is analog channel 11 on input, channel 111, group 1.
// - Port-0 pins 4 to 7 pulled up as inputs when pull-up bit one set.
// - Port-1 pins 0 to 3 pulled up as inputs when pull-up bit two set.
// - Port-1 pins 4 to 7 pulled up as inputs when pull-up bit three set.
// - Serial transmit pin drives only low when open-drain select is set.
// - Port-1 pin 6 feeds serial external clock on input with clock source 1.
// - Port-1 pin 6 outputs serial internal clock in mode 001, clock source 0.
package pin_select_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register indices
    localparam logic [3:0] OFF_PORT0_DATA = 4'h0;
    localparam logic [3:0] OFF_PORT1_DATA = 4'h1;
    localparam logic [3:0] OFF_PORT0_DIR = 4'h2;
    localparam logic [3:0] OFF_PORT1_DIR = 4'h3;
    localparam logic [3:0] OFF_CONV_CTRL = 4'h4;
    localparam logic [3:0] OFF_KEY_EN = 4'h5;
    localparam logic [3:0] OFF_PULLUP = 4'h6;
    localparam logic [3:0] OFF_SER_MODE = 4'h7;
    localparam logic [3:0] OFF_SER_CTRL = 4'h8;
    localparam logic [3:0] OFF_TMR_PIN = 4'h9;
    localparam logic [3:0] OFF_TMR_MODE = 4'hA;
    localparam logic [3:0] OFF_IRQ_EN = 4'hB;
    // Field positions
    localparam int CONV_CH_LSB = 0;
    localparam int CONV_GRP_BIT = 4;
    localparam int PU_ONE_BIT = 1;
    localparam int PU_TWO_BIT = 2;
    localparam int PU_THREE_BIT = 3;
    localparam int SER_MODE_LSB = 0;
    localparam int SER_CKSRC_BIT = 3;
    localparam int SER_OD_BIT = 5;
    localparam int TMR_SEL_BIT = 0;
    localparam int TMR_PROT_BIT = 2;
    localparam int TMR_MODE_LSB = 0;
    localparam int IRQ_ONE_BIT = 1;
    // Field values
    localparam logic [2:0] TMR_MODE_PULSE = 3'h1;
    localparam logic [2:0] SER_MODE_SYNC = 3'h1;
    localparam logic [2:0] SER_MODE_A7 = 3'h4;
    localparam logic [2:0] SER_MODE_A8 = 3'h5;
    localparam logic [2:0] SER_MODE_A9 = 3'h6;
    localparam logic [7:0] REG_RESET = 8'h00;
endpackage : pin_select_pkg

// *** pin_sync3.sv ***
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes: Output changes once stages two and three agree.
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [WIDTH-1:0] out_next;

    // Accept a level only where the last two stages agree
    always_comb begin
        out_next = out_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                out_next[i] = s3_reg[i];
            end
        end
    end

    // Shift chain
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule : pin_sync3

// *** port_pin_function_select.sv ***
// Purpose: Function select for port-0 pins 6,7 and port-1 pins 0..7.
// Assumes: Plain register port, read data one cycle after read strobe.
// Notes: Pins are split into input, output and output enable signals.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module port_pin_function_select (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port
    input wire logic [pin_select_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pin_select_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [pin_select_pkg::DATA_W-1:0] reg_rdata,
    // Port 0 pins (bits 6 and 7 are shared here)
    input wire logic [7:0] port0_pin_in,
    output logic [7:0] port0_pin_out,
    output logic [7:0] port0_pin_oe,
    output logic [7:0] port0_pullup,
    // Port 1 pins
    input wire logic [7:0] port1_pin_in,
    output logic [7:0] port1_pin_out,
    output logic [7:0] port1_pin_oe,
    output logic [7:0] port1_pullup,
    // Analog routing, one bit per channel 0..11
    output logic [11:0] analog_route,
    // Key-interrupt inputs
    output logic [3:0] key_input,
    // Serial unit
    input wire logic serial_transmit,
    input wire logic serial_clock_out,
    output logic serial_receive,
    output logic serial_clock_in,
    // Timer and external interrupt
    input wire logic timer_pulse,
    output logic timer_input,
    output logic ext_irq_one
);
    import pin_select_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Register file
    // Port latches and direction bits
    logic [7:0] port0_latch_reg;
    logic [7:0] port1_latch_reg;
    logic [7:0] port0_direction_reg;
    logic [7:0] port1_direction_reg;
    // Control registers of the units that share these pins
    logic [7:0] converter_control_zero_reg;
    logic [7:0] key_input_enable_reg;
    logic [7:0] pullup_control_first_reg;
    logic [7:0] serial_mode_reg;
    logic [7:0] serial_control_reg;
    logic [7:0] timer_pin_control_reg;
    logic [7:0] timer_mode_reg;
    logic [7:0] ext_irq_enable_reg;
    // Read data, registered so that it stands only in the cycle after the strobe
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    // Pin levels after the synchroniser
    logic [7:0] p0_sync;
    logic [7:0] p1_sync;

    // Pin levels are asynchronous: filter both ports before any decode reads them
    pin_sync3 #(.WIDTH(8)) sync0 (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(port0_pin_in),
        .sync_out(p0_sync)
    );
    pin_sync3 #(.WIDTH(8)) sync1 (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(port1_pin_in),
        .sync_out(p1_sync)
    );

    // Read value of a port: pin level on inputs, latch on outputs
    function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
                                             input logic [7:0] pin);
        port_read = (dir & latch) | (~dir & pin);
    endfunction : port_read

    // Analog route of one pin: only while its driver is off and group plus channel match
    function automatic logic analog_hit(input logic dir_bit, input logic [3:0] sel,
                                        input logic [3:0] code);
        analog_hit = !dir_bit && (sel == code);
    endfunction : analog_hit

    // Read mux
    always_comb begin
        rdata_next = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                OFF_PORT0_DATA: rdata_next = port_read(port0_direction_reg, port0_latch_reg, p0_sync);
                OFF_PORT1_DATA: rdata_next = port_read(port1_direction_reg, port1_latch_reg, p1_sync);
                OFF_PORT0_DIR: rdata_next = port0_direction_reg;
                OFF_PORT1_DIR: rdata_next = port1_direction_reg;
                OFF_CONV_CTRL: rdata_next = converter_control_zero_reg;
                OFF_KEY_EN: rdata_next = key_input_enable_reg;
                OFF_PULLUP: rdata_next = pullup_control_first_reg;
                OFF_SER_MODE: rdata_next = serial_mode_reg;
                OFF_SER_CTRL: rdata_next = serial_control_reg;
                OFF_TMR_PIN: rdata_next = timer_pin_control_reg;
                OFF_TMR_MODE: rdata_next = timer_mode_reg;
                OFF_IRQ_EN: rdata_next = ext_irq_enable_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Register writes and read data
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            port0_latch_reg <= REG_RESET;
            port1_latch_reg <= REG_RESET;
            port0_direction_reg <= REG_RESET;
            port1_direction_reg <= REG_RESET;
            converter_control_zero_reg <= REG_RESET;
            key_input_enable_reg <= REG_RESET;
            pullup_control_first_reg <= REG_RESET;
            serial_mode_reg <= REG_RESET;
            serial_control_reg <= REG_RESET;
            timer_pin_control_reg <= REG_RESET;
            timer_mode_reg <= REG_RESET;
            ext_irq_enable_reg <= REG_RESET;
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
            if (reg_write) begin
                unique case (reg_addr)
                    OFF_PORT0_DATA: port0_latch_reg <= reg_wdata;
                    OFF_PORT1_DATA: port1_latch_reg <= reg_wdata;
                    OFF_PORT0_DIR: port0_direction_reg <= reg_wdata;
                    OFF_PORT1_DIR: port1_direction_reg <= reg_wdata;
                    OFF_CONV_CTRL: converter_control_zero_reg <= reg_wdata;
                    OFF_KEY_EN: key_input_enable_reg <= reg_wdata;
                    OFF_PULLUP: pullup_control_first_reg <= reg_wdata;
                    OFF_SER_MODE: serial_mode_reg <= reg_wdata;
                    OFF_SER_CTRL: serial_control_reg <= reg_wdata;
                    OFF_TMR_PIN: timer_pin_control_reg <= reg_wdata;
                    OFF_TMR_MODE: timer_mode_reg <= reg_wdata;
                    OFF_IRQ_EN: ext_irq_enable_reg <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Decoded control fields
    logic [2:0] conv_ch;
    logic [2:0] ser_mode;
    logic [2:0] tmr_mode;
    logic [3:0] conv_sel;
    logic conv_grp;
    logic ser_cksrc;
    logic open_drain_select;
    logic timer_pin_select;
    logic timer_output_protect;
    logic tx_active;
    logic clk_out_active;
    logic timer_pulse_on;

    assign conv_ch = converter_control_zero_reg[CONV_CH_LSB +: 3];
    assign conv_grp = converter_control_zero_reg[CONV_GRP_BIT];
    assign conv_sel = {conv_grp, conv_ch};
    assign ser_mode = serial_mode_reg[SER_MODE_LSB +: 3];
    assign ser_cksrc = serial_mode_reg[SER_CKSRC_BIT];
    assign open_drain_select = serial_control_reg[SER_OD_BIT];
    assign timer_pin_select = timer_pin_control_reg[TMR_SEL_BIT];
    assign timer_output_protect = timer_pin_control_reg[TMR_PROT_BIT];
    assign tmr_mode = timer_mode_reg[TMR_MODE_LSB +: 3];
    assign tx_active = (ser_mode == SER_MODE_SYNC) || (ser_mode == SER_MODE_A7)
                       || (ser_mode == SER_MODE_A8) || (ser_mode == SER_MODE_A9);
    assign clk_out_active = (ser_mode == SER_MODE_SYNC) && !ser_cksrc;
    assign timer_pulse_on = (tmr_mode == TMR_MODE_PULSE) && !timer_output_protect;

    ////////////////////////////////////////////////////////////////////
    // Pin function decode
    // Next pin-side values
    logic [7:0] p0_out_next;
    logic [7:0] p0_oe_next;
    logic [7:0] p1_out_next;
    logic [7:0] p1_oe_next;
    logic [7:0] p0_pu_next;
    logic [7:0] p1_pu_next;
    logic [11:0] analog_next;
    logic [3:0] key_next;
    logic rx_next;
    logic ckin_next;
    logic tin_next;
    logic irq_next;
    logic tpin;
    // Registered pin-side values, so every output leaves from a flip-flop
    logic [7:0] out_reg0;
    logic [7:0] oe_reg0;
    logic [7:0] out_reg1;
    logic [7:0] oe_reg1;
    logic [7:0] pu_reg0;
    logic [7:0] pu_reg1;
    logic [11:0] analog_reg;
    logic [3:0] key_reg;
    logic rx_reg;
    logic ckin_reg;
    logic tin_reg;
    logic irq_reg;

    // Plain port behaviour, then peripheral overrides
    always_comb begin
        p0_out_next = port0_latch_reg;
        p0_oe_next = port0_direction_reg;
        p1_out_next = port1_latch_reg;
        p1_oe_next = port1_direction_reg;
        analog_next = 12'h000;
        // Analog channels on inputs
        analog_next[1] = analog_hit(port0_direction_reg[6], conv_sel, 4'h1);
        analog_next[0] = analog_hit(port0_direction_reg[7], conv_sel, 4'h0);
        analog_next[8] = analog_hit(port1_direction_reg[0], conv_sel, 4'hC);
        analog_next[9] = analog_hit(port1_direction_reg[1], conv_sel, 4'hD);
        analog_next[10] = analog_hit(port1_direction_reg[2], conv_sel, 4'hE);
        analog_next[11] = analog_hit(port1_direction_reg[3], conv_sel, 4'hF);
        key_next = ~port1_direction_reg[3:0] & key_input_enable_reg[3:0] & p1_sync[3:0];
        // Serial transmit overrides direction, optionally open drain
        if (tx_active) begin
            if (open_drain_select) begin
                p1_out_next[4] = 1'b0;
                p1_oe_next[4] = !serial_transmit;
            end else begin
                p1_out_next[4] = serial_transmit;
                p1_oe_next[4] = 1'b1;
            end
        end
        rx_next = p1_sync[5];
        // Serial clock pin
        if (clk_out_active) begin
            p1_out_next[6] = serial_clock_out;
            p1_oe_next[6] = 1'b1;
        end
        ckin_next = !port1_direction_reg[6] && ser_cksrc && p1_sync[6];
        // Timer pin on 5 when select is 1, on 7 when select is 0
        tpin = timer_pin_select ? p1_sync[5] : p1_sync[7];
        if (timer_pulse_on) begin
            if (timer_pin_select) begin
                p1_out_next[5] = timer_pulse;
                p1_oe_next[5] = 1'b1;
            end else begin
                p1_out_next[7] = timer_pulse;
                p1_oe_next[7] = 1'b1;
            end
            tin_next = 1'b0;
        end else begin
            tin_next = timer_pin_select ? (!port1_direction_reg[5] && tpin)
                                        : (!port1_direction_reg[7] && tpin);
        end
        irq_next = ext_irq_enable_reg[IRQ_ONE_BIT] && tin_next;
        // Pull-ups only on pins that are not driven
        p0_pu_next = 8'h00;
        p1_pu_next = 8'h00;
        p0_pu_next[7:4] = {4{pullup_control_first_reg[PU_ONE_BIT]}} & ~p0_oe_next[7:4];
        p1_pu_next[3:0] = {4{pullup_control_first_reg[PU_TWO_BIT]}} & ~p1_oe_next[3:0];
        p1_pu_next[7:4] = {4{pullup_control_first_reg[PU_THREE_BIT]}} & ~p1_oe_next[7:4];
    end

    // Register all pin-side outputs
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            out_reg0 <= 8'h00;
            oe_reg0 <= 8'h00;
            out_reg1 <= 8'h00;
            oe_reg1 <= 8'h00;
            pu_reg0 <= 8'h00;
            pu_reg1 <= 8'h00;
            analog_reg <= 12'h000;
            key_reg <= 4'h0;
            rx_reg <= 1'b0;
            ckin_reg <= 1'b0;
            tin_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            out_reg0 <= p0_out_next;
            oe_reg0 <= p0_oe_next;
            out_reg1 <= p1_out_next;
            oe_reg1 <= p1_oe_next;
            pu_reg0 <= p0_pu_next;
            pu_reg1 <= p1_pu_next;
            analog_reg <= analog_next;
            key_reg <= key_next;
            rx_reg <= rx_next;
            ckin_reg <= ckin_next;
            tin_reg <= tin_next;
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign port0_pin_out = out_reg0;
    assign port0_pin_oe = oe_reg0;
    assign port0_pullup = pu_reg0;
    assign port1_pin_out = out_reg1;
    assign port1_pin_oe = oe_reg1;
    assign port1_pullup = pu_reg1;
    assign analog_route = analog_reg;
    assign key_input = key_reg;
    assign serial_receive = rx_reg;
    assign serial_clock_in = ckin_reg;
    assign timer_input = tin_reg;
    assign ext_irq_one = irq_reg;
endmodule : port_pin_function_select

// *** pin_select_chk_sva.sv ***
// Purpose: Port-level checks for the shared-pin function selector.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Sees only top-level ports; attached by bind below.
`timescale 1ns/10ps
module pin_select_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Watched ports
    input wire logic reg_read,
    input wire logic [pin_select_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [7:0] port0_pin_oe,
    input wire logic [7:0] port0_pullup,
    input wire logic [7:0] port1_pin_oe,
    input wire logic [7:0] port1_pullup,
    input wire logic [11:0] analog_route,
    input wire logic [3:0] key_input
);
    import pin_select_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_pullup_p0_input: assert property ((port0_pullup & port0_pin_oe) == 8'h00)
        else $error("Port 0 pull-up on a driven pin");
    a_pullup_p1_input: assert property ((port1_pullup & port1_pin_oe) == 8'h00)
        else $error("Port 1 pull-up on a driven pin");
    a_pullup_group_two: assert property (port1_pullup[3:0] != 4'h0 |->
        port1_pullup[3:0] == ~port1_pin_oe[3:0]) else $error("Pull-up group two split");
    a_pullup_group_three: assert property (port1_pullup[7:4] != 4'h0 |->
        port1_pullup[7:4] == ~port1_pin_oe[7:4]) else $error("Pull-up group three split");
    a_analog_one_channel: assert property ($onehot0(analog_route))
        else $error("More than one analog channel routed");
    a_analog_zero_input: assert property (analog_route[0] |-> !port0_pin_oe[7])
        else $error("Analog channel 0 on a driven pin");
    a_analog_one_input: assert property (analog_route[1] |-> !port0_pin_oe[6])
        else $error("Analog channel 1 on a driven pin");
    a_analog_high_input: assert property ((analog_route[11:8] & port1_pin_oe[3:0]) == 4'h0)
        else $error("Analog channel 8 to 11 on a driven pin");
    a_key_input_only: assert property ((key_input & port1_pin_oe[3:0]) == 4'h0)
        else $error("Key input fed from a driven pin");
    a_read_data_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("Read data outside its slot");
    // Main scenarios reached
    c_analog: cover property (analog_route != 12'h000);
    c_key: cover property (key_input != 4'h0);
    c_transmit: cover property (port1_pin_oe[4]);
endmodule : pin_select_chk
bind port_pin_function_select pin_select_chk i_chk (.sys_clk, .resetn, .reg_read,
    .reg_rdata, .port0_pin_oe, .port0_pullup, .port1_pin_oe, .port1_pullup,
    .analog_route, .key_input);

// *** pin_far_side.sv ***
// Purpose: External pin model for one 8-bit port.
// Assumes: Driven by the same clock as the block.
// Notes: A released pin with no external driver and no pull-up shows a pattern that toggles each cycle.
`timescale 1ns/10ps
module pin_far_side (
    // Clock
    input wire logic sys_clk,
    // Block side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_en,
    // External drivers
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    logic [7:0] float_reg = 8'h55;
    // Floating level changes every cycle
    always_ff @(posedge sys_clk) begin
        float_reg <= ~float_reg;
    end
    // Block driver wins, then external, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                pull_en[i] ? 1'b1 : float_reg[i];
        end
    end
endmodule : pin_far_side

// *** port_pin_function_select_tb_top.sv ***
// Purpose: Self-checking bench for the shared-pin function selector.
// Assumes: 200 MHz clock, reset held six cycles.
// Notes: Pin-derived outputs are sampled after the input synchroniser settles.
`timescale 1ns/10ps
module port_pin_function_select_tb_top;
    import pin_select_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic serial_transmit = 1'b0;
    logic serial_clock_out = 1'b0;
    logic timer_pulse = 1'b0;
    logic [7:0] p0_ext = 8'h00;
    logic [7:0] p1_ext = 8'h00;
    logic [DATA_W-1:0] reg_rdata;
    logic [7:0] port0_pin_in, port0_pin_out, port0_pin_oe, port0_pullup;
    logic [7:0] port1_pin_in, port1_pin_out, port1_pin_oe, port1_pullup;
    logic [11:0] analog_route;
    logic [3:0] key_input;
    logic serial_receive, serial_clock_in, timer_input, ext_irq_one;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    port_pin_function_select i_dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .port0_pin_in, .port0_pin_out, .port0_pin_oe, .port0_pullup,
        .port1_pin_in, .port1_pin_out, .port1_pin_oe, .port1_pullup, .analog_route,
        .key_input, .serial_transmit, .serial_clock_out, .serial_receive, .serial_clock_in,
        .timer_pulse, .timer_input, .ext_irq_one);
    pin_far_side i_pins0 (.sys_clk, .pin_out(port0_pin_out), .pin_oe(port0_pin_oe),
        .pull_en(port0_pullup), .ext_val(p0_ext), .ext_en(8'hFF), .pin_in(port0_pin_in));
    pin_far_side i_pins1 (.sys_clk, .pin_out(port1_pin_out), .pin_oe(port1_pin_oe),
        .pull_en(port1_pullup), .ext_val(p1_ext), .ext_en(8'hFF), .pin_in(port1_pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 chk({4'h0, reg_rdata}, {4'h0, exp});
    endtask : rd
    task automatic settle;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, unmapped index, latch versus pin reads
    task automatic t_port;
        rd(OFF_PORT1_DIR, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        wr(OFF_PORT1_DATA, 8'hA5);
        wr(OFF_PORT1_DIR, 8'h0F);
        wr(OFF_PORT0_DATA, 8'h80);
        wr(OFF_PORT0_DIR, 8'h80);
        p1_ext <= 8'h3C;
        p0_ext <= 8'h40;
        settle();
        rd(OFF_PORT1_DATA, 8'h35);
        rd(OFF_PORT0_DATA, 8'hC0);
        chk({port1_pin_oe, port1_pin_out[3:0]}, 12'h0F5);
        chk({port0_pin_oe, port0_pin_out[7:4]}, 12'h808);
    endtask : t_port
    // Every analog channel code, then a driven pin
    task automatic t_analog;
        logic [7:0] ctl [6] = '{8'h01, 8'h00, 8'h14, 8'h15, 8'h16, 8'h17};
        logic [11:0] exp [6] = '{12'h002, 12'h001, 12'h100, 12'h200, 12'h400, 12'h800};
        wr(OFF_PORT0_DIR, 8'h00);
        wr(OFF_PORT1_DIR, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(OFF_CONV_CTRL, ctl[i]);
            settle();
            chk(analog_route, exp[i]);
        end
        wr(OFF_PORT1_DIR, 8'h08);
        settle();
        chk(analog_route, 12'h000);
    endtask : t_analog
    // Pull-up groups only on input pins
    task automatic t_pullup;
        wr(OFF_PORT0_DIR, 8'h40);
        wr(OFF_PORT1_DIR, 8'h11);
        wr(OFF_PULLUP, 8'h0E);
        settle();
        chk({port0_pullup[7:4], port1_pullup}, 12'hBEE);
        wr(OFF_PULLUP, 8'h04);
        settle();
        chk({port0_pullup[7:4], port1_pullup}, 12'h00E);
    endtask : t_pullup
    // Key inputs gated by enable and direction
    task automatic t_key;
        wr(OFF_PORT1_DIR, 8'h02);
        p1_ext <= 8'h0F;
        wr(OFF_KEY_EN, 8'h0F);
        settle();
        chk({8'h00, key_input}, 12'h00D);
        wr(OFF_PORT1_DIR, 8'h00);
        wr(OFF_KEY_EN, 8'h05);
        settle();
        chk({8'h00, key_input}, 12'h005);
    endtask : t_key
    // Transmit per mode, clock both ways, open drain
    task automatic t_serial;
        logic [7:0] md [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
        logic ex [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        @(posedge sys_clk);
        serial_transmit <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(OFF_SER_MODE, md[i]);
            settle();
            chk({port1_pin_oe[4], port1_pin_out[4] & port1_pin_oe[4]}, {ex[i], ex[i]});
        end
        wr(OFF_SER_MODE, 8'h01);
        serial_clock_out <= 1'b1;
        settle();
        chk({port1_pin_oe[6], port1_pin_out[6]}, 12'h003);
        wr(OFF_SER_MODE, 8'h09);
        p1_ext <= 8'h40;
        settle();
        chk({port1_pin_oe[6], serial_clock_in}, 12'h001);
        wr(OFF_SER_CTRL, 8'h20);
        settle();
        chk({11'h000, port1_pin_oe[4]}, 12'h000);
        @(posedge sys_clk);
        serial_transmit <= 1'b0;
        settle();
        chk({port1_pin_oe[4], port1_pin_out[4]}, 12'h002);
    endtask : t_serial
    // Timer pin select, pulse output, protection, interrupt pass
    task automatic t_timer;
        wr(OFF_TMR_PIN, 8'h01);
        timer_pulse <= 1'b1;
        wr(OFF_TMR_MODE, 8'h01);
        settle();
        chk({port1_pin_oe[5], port1_pin_out[5]}, 12'h003);
        wr(OFF_TMR_PIN, 8'h05);
        settle();
        chk({11'h000, port1_pin_oe[5]}, 12'h000);
        wr(OFF_TMR_PIN, 8'h00);
        wr(OFF_TMR_MODE, 8'h00);
        wr(OFF_IRQ_EN, 8'h02);
        p1_ext <= 8'hA0;
        settle();
        chk({serial_receive, timer_input, ext_irq_one}, 12'h007);
        wr(OFF_IRQ_EN, 8'h00);
        settle();
        chk({timer_input, ext_irq_one}, 12'h002);
    endtask : t_timer
    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        t_port();
        t_analog();
        t_pullup();
        t_key();
        t_serial();
        t_timer();
        end_of_test();
    end
endmodule : port_pin_function_select_tb_top
